// [rtl/dfm_fault_monitor.sv]
`timescale 1ns/1ns
`include "dfm_map.svh"

module dfm_fault_monitor #(
    parameter int CH = 32,
    parameter bit CONNECTOR = 1'b1,
    parameter bit IS_OUTPUT = 1'b1,
    parameter bit TRANSISTOR = 1'b1,
    parameter bit FUSED = 1'b0,
    parameter bit FAST_IN = 1'b0,
    parameter int RETRY_CYCLES = `DFM_RETRY_S * `DFM_CLK_HZ,
    // Divide first: the plain product overflows a 32-bit int
    parameter int FLASH_CYCLES = (`DFM_CLK_HZ / 1000) * `DFM_FLASH_HALF_MS,
    parameter int NSUP = CONNECTOR ? (CH / `DFM_SUP_SPAN) : 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic dialog_fault,
    input wire logic internal_fault,
    input wire logic [NSUP-1:0] supply_low,
    input wire logic tb_missing,
    input wire logic [CH-1:0] short_det,
    input wire logic [CH-1:0] fuse_blown,
    input wire logic [CH-1:0] out_cmd,
    input wire logic [CH-1:0] in_state,
    output logic [CH-1:0] out_drive,
    output logic err_lamp,
    output logic run_lamp,
    output logic io_lamp,
    output logic [CH-1:0] ch_lamp
);

    localparam int NGRP = CH / `DFM_GRP_SIZE;
    localparam int PW = NSUP + 1 + 2 * CH;
    localparam int TCW = 28;
    localparam int FCW = 24;
    localparam logic [TCW-1:0] RETRY_LIM = TCW'(RETRY_CYCLES - 1);
    localparam logic [FCW-1:0] FLASH_LIM = FCW'(FLASH_CYCLES - 1);

    function automatic logic [63:0] pad64(input logic [CH-1:0] v);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < CH; i++) begin
            r[i] = v[i];
        end
        return r;
    endfunction

    function automatic int sup_of(input int ch);
        return CONNECTOR ? (ch / `DFM_SUP_SPAN) : 0;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus request bundle

    dfm_pkg::dfm_bus_req_t req;
    assign req.addr = addr;
    assign req.wdata = wdata;
    assign req.wr = wr_en;
    assign req.rd = rd_en;

    ////////////////////////////////////////////////////////////////////
    // Pin input filters: three stages, change taken when 2nd and 3rd agree

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] s1_reg;
    logic [PW-1:0] s2_reg;
    logic [PW-1:0] s3_reg;
    logic [PW-1:0] filt_reg;
    logic [PW-1:0] agree;

    assign pin_raw = {supply_low, tb_missing, short_det, fuse_blown};
    assign agree = s2_reg ~^ s3_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt_reg <= '0;
        end else begin
            filt_reg <= (filt_reg & ~agree) | (s3_reg & agree);
        end
    end

    logic [CH-1:0] fuse_f;
    logic [CH-1:0] short_f;
    logic tb_f;
    logic [NSUP-1:0] sup_f;

    assign fuse_f = filt_reg[CH-1:0];
    assign short_f = filt_reg[2*CH-1:CH];
    assign tb_f = filt_reg[2*CH];
    assign sup_f = filt_reg[PW-1:2*CH+1];

    ////////////////////////////////////////////////////////////////////
    // Level faults: follow the filtered pins, no latching

    logic [NSUP-1:0] volt_flt;
    logic tb_flt;
    logic [CH-1:0] ch_volt;
    logic [CH-1:0] ch_fuse;

    // Relay and triac outputs carry no supply monitor
    assign volt_flt = (IS_OUTPUT && !TRANSISTOR) ? '0 : sup_f;
    // Connector modules rely on the per-connector supply monitor instead
    assign tb_flt = CONNECTOR ? 1'b0 : tb_f;
    assign ch_fuse = FUSED ? fuse_f : '0;

    always_comb begin
        ch_volt = '0;
        for (int i = 0; i < CH; i++) begin
            ch_volt[i] = volt_flt[sup_of(i)];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers

    logic auto_reg;
    logic [5:0] chsel_reg;
    logic [NGRP-1:0] react_cmd;
    logic wr_ctrl;

    assign wr_ctrl = req.wr && (req.addr == `DFM_OFS_CTRL);
    assign react_cmd = (req.wr && (req.addr == `DFM_OFS_REACT)) ?
        req.wdata[NGRP-1:0] : '0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auto_reg <= `DFM_CTRL_RESET;
        end else if (wr_ctrl) begin
            auto_reg <= req.wdata[`DFM_CTRL_AUTO_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chsel_reg <= 6'h00;
        end else if (req.wr && (req.addr == `DFM_OFS_CHSEL)) begin
            chsel_reg <= req.wdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output tripping and group reactivation

    logic [CH-1:0] trip_reg;
    logic [CH-1:0] trip_set;
    logic [CH-1:0] trip_clr;
    logic [CH-1:0] out_drive_reg;
    logic [NGRP-1:0] grp_trip;
    logic [NGRP-1:0] grp_prev_reg;
    logic [NGRP-1:0] grp_ready;
    logic [NGRP-1:0] grp_fire;
    logic [NGRP-1:0] grp_restart;

    // Only a driven transistor output can trip
    assign trip_set = (IS_OUTPUT && TRANSISTOR) ?
        (short_f & out_drive_reg) : '0;

    always_comb begin
        grp_trip = '0;
        trip_clr = '0;
        for (int g = 0; g < NGRP; g++) begin
            grp_trip[g] = |trip_reg[g*`DFM_GRP_SIZE +: `DFM_GRP_SIZE];
            // Retry clears only the trip flags of its own group
            trip_clr[g*`DFM_GRP_SIZE +: `DFM_GRP_SIZE] =
                {`DFM_GRP_SIZE{grp_fire[g]}};
        end
    end

    // A trip set beats the retry clear; a persisting short retrips once the retried output is driven again
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trip_reg <= '0;
        end else begin
            trip_reg <= trip_set | (trip_reg & ~trip_clr);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grp_prev_reg <= '0;
        end else begin
            grp_prev_reg <= grp_trip;
        end
    end

    always_comb begin
        grp_fire = '0;
        grp_restart = '0;
        for (int g = 0; g < NGRP; g++) begin
            if (auto_reg) begin
                grp_fire[g] = grp_trip[g] && grp_ready[g];
            end else begin
                grp_fire[g] = grp_trip[g] && grp_ready[g] &&
                    react_cmd[g];
            end
            // Automatic mode restarts the timer when the group trip flag rises; an already expired timer fires in the trip cycle
            grp_restart[g] = grp_fire[g] ||
                (auto_reg && grp_trip[g] && !grp_prev_reg[g]);
        end
    end

    for (genvar g = 0; g < NGRP; g++) begin : g_timer
        dfm_retry_timer #(
            .CW(TCW),
            .LIMIT(RETRY_LIM)
        ) u_timer (
            .clk(clk),
            .resetn(resetn),
            .restart(grp_restart[g]),
            .ready(grp_ready[g])
        );
    end

    // Tripped, low-supply and blown-fuse channels drive zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_drive_reg <= '0;
        end else if (IS_OUTPUT) begin
            out_drive_reg <= out_cmd & ~trip_reg & ~trip_set &
                ~ch_volt & ~ch_fuse;
        end else begin
            out_drive_reg <= '0;
        end
    end

    assign out_drive = out_drive_reg;

    ////////////////////////////////////////////////////////////////////
    // Status words

    dfm_pkg::dfm_modstat_t modstat;
    dfm_pkg::dfm_chstat_t chstat;
    logic [CH-1:0] ch_fault;
    logic [63:0] sel_vec;

    assign modstat.internal = internal_fault;
    assign modstat.dialog = dialog_fault;
    assign modstat.ext_volt = |volt_flt;
    assign modstat.term_block = tb_flt;
    assign modstat.trip = |trip_reg;
    assign modstat.fuse = |ch_fuse;

    // Channel fault flag gathers every per-channel cause
    assign ch_fault = trip_reg | ch_volt | ch_fuse;

    always_comb begin
        sel_vec = '0;
        sel_vec[chsel_reg] = 1'b1;
        chstat.trip = |(pad64(trip_reg) & sel_vec);
        chstat.ext_volt = |(pad64(ch_volt) & sel_vec);
        chstat.fuse = |(pad64(ch_fuse) & sel_vec);
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky on rising fault, write one to clear

    logic [5:0] int_stat_reg;
    logic [5:0] int_mask_reg;
    logic [5:0] mod_prev_reg;
    logic [5:0] int_set;
    logic [5:0] int_clr;

    assign int_set = modstat & ~mod_prev_reg;
    assign int_clr = (req.wr && (req.addr == `DFM_OFS_INTSTAT)) ?
        req.wdata[5:0] : 6'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mod_prev_reg <= 6'h00;
        end else begin
            mod_prev_reg <= modstat;
        end
    end

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_stat_reg <= 6'h00;
        end else begin
            int_stat_reg <= int_set | (int_stat_reg & ~int_clr);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_mask_reg <= `DFM_INTMASK_RESET;
        end else if (req.wr && (req.addr == `DFM_OFS_INTMASK)) begin
            int_mask_reg <= req.wdata[5:0];
        end
    end

    assign irq = |(int_stat_reg & int_mask_reg);

    ////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe

    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    logic [63:0] flt64;
    logic [63:0] sht64;

    assign flt64 = pad64(ch_fault);
    assign sht64 = pad64(trip_reg);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (req.addr)
            `DFM_OFS_CTRL: rd_mux[0] = auto_reg;
            `DFM_OFS_MODSTAT: rd_mux[5:0] = modstat;
            `DFM_OFS_CHFLT_LO: rd_mux = flt64[31:0];
            `DFM_OFS_CHFLT_HI: rd_mux = flt64[63:32];
            `DFM_OFS_SHORT_LO: rd_mux = sht64[31:0];
            `DFM_OFS_SHORT_HI: rd_mux = sht64[63:32];
            `DFM_OFS_TRIP: rd_mux[NGRP-1:0] = grp_trip;
            `DFM_OFS_CHSEL: rd_mux[5:0] = chsel_reg;
            `DFM_OFS_CHSTAT: rd_mux[2:0] = chstat;
            `DFM_OFS_INTSTAT: rd_mux[5:0] = int_stat_reg;
            `DFM_OFS_INTMASK: rd_mux[5:0] = int_mask_reg;
            `DFM_OFS_SUPPLY: rd_mux[NSUP-1:0] = volt_flt;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Lamps

    logic [FCW-1:0] flash_cnt_reg;
    logic flash_reg;
    dfm_pkg::dfm_lamp_t err_mode;
    dfm_pkg::dfm_lamp_t io_mode;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flash_cnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (flash_cnt_reg == FLASH_LIM) begin
            flash_cnt_reg <= '0;
            flash_reg <= ~flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + {{(FCW-1){1'b0}}, 1'b1};
        end
    end

    // Internal fault outranks dialog fault on the shared lamp
    always_comb begin
        if (internal_fault) begin
            err_mode = dfm_pkg::DFM_LAMP_ON;
        end else if (dialog_fault && (IS_OUTPUT || FAST_IN)) begin
            err_mode = dfm_pkg::DFM_LAMP_FLASH;
        end else begin
            err_mode = dfm_pkg::DFM_LAMP_OFF;
        end
    end

    always_comb begin
        if (modstat.ext_volt || modstat.trip || modstat.fuse) begin
            io_mode = dfm_pkg::DFM_LAMP_ON;
        end else if (tb_flt) begin
            io_mode = dfm_pkg::DFM_LAMP_FLASH;
        end else begin
            io_mode = dfm_pkg::DFM_LAMP_OFF;
        end
    end

    function automatic logic lamp_level(input dfm_pkg::dfm_lamp_t m,
                                        input logic fl);
        case (m)
            dfm_pkg::DFM_LAMP_ON: return 1'b1;
            dfm_pkg::DFM_LAMP_FLASH: return fl;
            default: return 1'b0;
        endcase
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_lamp <= 1'b0;
            run_lamp <= 1'b0;
            io_lamp <= 1'b0;
        end else begin
            err_lamp <= lamp_level(err_mode, flash_reg);
            run_lamp <= ~internal_fault;
            io_lamp <= lamp_level(io_mode, flash_reg);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ch_lamp <= '0;
        end else begin
            for (int i = 0; i < CH; i++) begin
                if (trip_reg[i]) begin
                    ch_lamp[i] <= flash_reg;
                end else if (IS_OUTPUT) begin
                    ch_lamp[i] <= out_drive_reg[i];
                end else begin
                    ch_lamp[i] <= in_state[i];
                end
            end
        end
    end

endmodule

// [pkg/dfm_map.svh]
// Functional notes
// - Dialog fault flashes error lamp on outputs and fast inputs, sets bit
// - Internal fault: error lamp steady, run off
// - Low supply lights field lamp, reports
// - One monitor, or one per 16 channels
// - Supply fault puts affected channels faulty
// - Relay or triac outputs never report supply
// - Missing terminal block flashes field lamp
// - Connector modules skip presence detection
// - Short trips output, flashes channel lamp
// - Readable short bits and group trip bits
// - Trip sets channel flag and status code
// - Low sensor supply flags affected channel words
// - Low actuator supply forces outputs zero
// - Blown fuse lights lamp, flags channels
// - Automatic retry every ten seconds
// - Commanded retry spaced ten seconds apart
// - Retry acts per eight-channel group only
`ifndef DFM_MAP_SVH
`define DFM_MAP_SVH

`define DFM_CLK_HZ 20000000
`define DFM_RETRY_S 10
`define DFM_FLASH_HALF_MS 250
`define DFM_GRP_SIZE 8
`define DFM_SUP_SPAN 16

`define DFM_OFS_CTRL 8'h00
`define DFM_OFS_REACT 8'h04
`define DFM_OFS_MODSTAT 8'h08
`define DFM_OFS_CHFLT_LO 8'h0C
`define DFM_OFS_CHFLT_HI 8'h10
`define DFM_OFS_SHORT_LO 8'h14
`define DFM_OFS_SHORT_HI 8'h18
`define DFM_OFS_TRIP 8'h1C
`define DFM_OFS_CHSEL 8'h20
`define DFM_OFS_CHSTAT 8'h24
`define DFM_OFS_INTSTAT 8'h28
`define DFM_OFS_INTMASK 8'h2C
`define DFM_OFS_SUPPLY 8'h30

`define DFM_CTRL_AUTO_BIT 0
`define DFM_CTRL_RESET 1'h0
`define DFM_INTMASK_RESET 6'h00

`endif

// [pkg/dfm_pkg.sv]
package dfm_pkg;

    // Gray-ordered lamp drive modes
    typedef enum logic [1:0] {
        DFM_LAMP_OFF = 2'h0,
        DFM_LAMP_ON = 2'h1,
        DFM_LAMP_FLASH = 2'h3
    } dfm_lamp_t;

    typedef struct packed {
        logic fuse;
        logic trip;
        logic term_block;
        logic ext_volt;
        logic dialog;
        logic internal;
    } dfm_modstat_t;

    typedef struct packed {
        logic fuse;
        logic ext_volt;
        logic trip;
    } dfm_chstat_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dfm_bus_req_t;

endpackage

// [rtl/dfm_retry_timer.sv]
`timescale 1ns/1ns
// Spacing timer for one channel group; ready once LIMIT cycles passed
module dfm_retry_timer #(
    parameter int CW = 28,
    parameter logic [CW-1:0] LIMIT = '1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic restart,
    output logic ready
);

    logic [CW-1:0] count_reg;

    // Starts expired so the first commanded retry is not held off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= LIMIT;
        end else if (restart) begin
            count_reg <= '0;
        end else if (count_reg != LIMIT) begin
            count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    assign ready = (count_reg == LIMIT);

endmodule

// [sim/dfm_fault_monitor_props.sv]
`timescale 1ns/1ns
module dfm_fault_monitor_props #(
    parameter int CH = 32,
    parameter int NSUP = 2,
    parameter int FLASH_CYCLES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic dialog_fault,
    input wire logic internal_fault,
    input wire logic [NSUP-1:0] supply_low,
    input wire logic [CH-1:0] short_det,
    input wire logic [CH-1:0] out_cmd,
    input wire logic [CH-1:0] out_drive,
    input wire logic err_lamp,
    input wire logic run_lamp,
    input wire logic io_lamp,
    input wire logic [CH-1:0] ch_lamp
);
    // One full flash period plus slack for the registered channel lamp
    localparam int FLW = 2 * FLASH_CYCLES + 2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    sequence s_dialog;
        (dialog_fault && !internal_fault) [*8];
    endsequence
    sequence s_low0;
        supply_low[0] [*8];
    endsequence
    // A drop of the drive while commanded and shorted is a trip
    sequence s_trip0;
        short_det[0] && out_cmd[0] && !supply_low[0] && $fell(out_drive[0]);
    endsequence
    AST_RDATA_IDLE: assert property (
        !$past(rd_en) |-> rdata == 32'h0000_0000)
        else $error("read data not idle");
    AST_DIALOG_FLASH: assert property (
        s_dialog |-> err_lamp != $past(err_lamp, FLASH_CYCLES))
        else $error("error lamp not flashing");
    AST_INTERNAL: assert property (
        internal_fault [*3] |-> err_lamp && !run_lamp)
        else $error("internal fault lamps wrong");
    AST_LOW_LAMP: assert property (
        s_low0 |-> io_lamp)
        else $error("field lamp off on low supply");
    AST_LOW_DRIVE0: assert property (
        s_low0 |-> out_drive[15:0] == 16'h0000)
        else $error("outputs driven on low supply");
    AST_LOW_DRIVE1: assert property (
        supply_low[NSUP-1] [*8] |-> out_drive[CH-1 -: 16] == 16'h0000)
        else $error("upper group driven on low supply");
    AST_TRIP_OFF: assert property (
        short_det[0] [*8] ##0 out_drive[0] |-> ##[1:3] !out_drive[0])
        else $error("shorted output not tripped");
    AST_TRIP_LAMP: assert property (
        s_trip0 |-> ##[1:FLW] $changed(ch_lamp[0]))
        else $error("channel lamp not flashing");
    AST_TRIP_IO: assert property (
        s_trip0 |-> ##[1:3] io_lamp)
        else $error("field lamp off on trip");
endmodule

bind dfm_fault_monitor dfm_fault_monitor_props #(
    .CH(CH),
    .NSUP(NSUP),
    .FLASH_CYCLES(FLASH_CYCLES)
) u_props (
    .clk(clk),
    .resetn(resetn),
    .rd_en(rd_en),
    .rdata(rdata),
    .dialog_fault(dialog_fault),
    .internal_fault(internal_fault),
    .supply_low(supply_low),
    .short_det(short_det),
    .out_cmd(out_cmd),
    .out_drive(out_drive),
    .err_lamp(err_lamp),
    .run_lamp(run_lamp),
    .io_lamp(io_lamp),
    .ch_lamp(ch_lamp)
);

// [sim/dfm_host_model.sv]
`timescale 1ns/1ns
`include "dfm_map.svh"
module dfm_host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rdata
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // Released data shows the inverse, never a stale copy
        wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Each retry is commanded; spacing is the module's job
    task automatic react(input logic [31:0] groups);
        wr(`DFM_OFS_REACT, groups);
    endtask
endmodule

// [sim/dfm_fault_monitor_tb_top.sv]
`timescale 1ns/1ns
`include "dfm_map.svh"
module dfm_fault_monitor_tb_top;
    localparam int RETRY = 50;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata;
    logic irq;
    logic dialog_fault = 1'b0;
    logic internal_fault = 1'b0;
    logic [1:0] supply_low = 2'h0;
    logic tb_missing = 1'b0;
    logic [31:0] short_det = 32'h0;
    logic [31:0] out_cmd = 32'h0;
    logic [31:0] out_drive;
    logic err_lamp;
    logic run_lamp;
    logic io_lamp;
    logic [31:0] ch_lamp;
    logic [31:0] fuse_v = 32'h0;
    logic [31:0] in_v = 32'h0;
    logic [31:0] rdata_b;
    logic [15:0] drive_b;
    logic io_b;
    int bad_count = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    dfm_fault_monitor #(.RETRY_CYCLES(RETRY), .FLASH_CYCLES(4)) DUT (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .dialog_fault(dialog_fault), .internal_fault(internal_fault),
        .supply_low(supply_low), .tb_missing(tb_missing),
        .short_det(short_det), .fuse_blown(fuse_v), .out_cmd(out_cmd),
        .in_state(in_v), .out_drive(out_drive), .err_lamp(err_lamp),
        .run_lamp(run_lamp), .io_lamp(io_lamp), .ch_lamp(ch_lamp));
    // Fused terminal-block variant shares the bus and the lower pins
    dfm_fault_monitor #(.CH(16), .CONNECTOR(1'b0), .FUSED(1'b1),
        .RETRY_CYCLES(RETRY), .FLASH_CYCLES(4)) DUT_B (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_b), .irq(),
        .dialog_fault(dialog_fault), .internal_fault(internal_fault),
        .supply_low(supply_low[0]), .tb_missing(tb_missing),
        .short_det(short_det[15:0]), .fuse_blown(fuse_v[15:0]),
        .out_cmd(out_cmd[15:0]), .in_state(in_v[15:0]),
        .out_drive(drive_b), .err_lamp(), .run_lamp(), .io_lamp(io_b),
        .ch_lamp());
    dfm_host_model host (.clk(clk), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic rchkb(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.rd(a, d);
        chk(rdata_b, exp);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic close_out;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Whole run is well under a thousand cycles
    initial begin
        w(3000);
        bad_count++;
        close_out();
    end
    initial begin
        int cnt;
        logic prev;
        w(5);
        resetn <= 1'b1;
        rchk(`DFM_OFS_CTRL, 32'h0);
        rchk(`DFM_OFS_INTMASK, 32'h0);
        host.wr(8'h3C, 32'hFFFF_FFFF);
        rchk(8'h3C, 32'h0);
        w(1);
        internal_fault <= 1'b1;
        w(10);
        chk({30'h0, err_lamp, run_lamp}, 32'h2);
        rchk(`DFM_OFS_MODSTAT, 32'h1);
        w(1);
        internal_fault <= 1'b0;
        dialog_fault <= 1'b1;
        w(20);
        rchk(`DFM_OFS_MODSTAT, 32'h2);
        rchk(`DFM_OFS_INTSTAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        host.wr(`DFM_OFS_INTMASK, 32'h2);
        w(1);
        chk({31'h0, irq}, 32'h1);
        host.wr(`DFM_OFS_INTSTAT, 32'h3);
        w(1);
        chk({31'h0, irq}, 32'h0);
        dialog_fault <= 1'b0;
        out_cmd <= 32'hFFFF_FFFF;
        tb_missing <= 1'b1;
        w(10);
        chk(out_drive, 32'hFFFF_FFFF);
        @(negedge clk);
        prev = io_b;
        repeat (4) @(negedge clk);
        chk({31'h0, io_b ^ prev}, 32'h1);
        w(1);
        supply_low <= 2'h1;
        w(10);
        chk(out_drive, 32'hFFFF_0000);
        chk({16'h0, drive_b}, 32'h0);
        chk({31'h0, io_lamp}, 32'h1);
        rchk(`DFM_OFS_SUPPLY, 32'h1);
        rchk(`DFM_OFS_MODSTAT, 32'h4);
        rchk(`DFM_OFS_CHFLT_LO, 32'h0000_FFFF);
        host.wr(`DFM_OFS_CHSEL, 32'h3);
        rchk(`DFM_OFS_CHSTAT, 32'h2);
        w(1);
        supply_low <= 2'h2;
        w(10);
        chk(out_drive, 32'h0000_FFFF);
        chk({16'h0, drive_b}, 32'hFFFF);
        rchk(`DFM_OFS_CHFLT_LO, 32'hFFFF_0000);
        w(1);
        supply_low <= 2'h0;
        tb_missing <= 1'b0;
        w(10);
        chk(out_drive, 32'hFFFF_FFFF);
        fuse_v <= 32'h6;
        w(10);
        chk({16'h0, drive_b}, 32'hFFF9);
        chk({31'h0, io_b}, 32'h1);
        rchkb(`DFM_OFS_CHFLT_LO, 32'h6);
        w(1);
        fuse_v <= 32'h0;
        w(10);
        chk({16'h0, drive_b}, 32'hFFFF);
        short_det <= 32'h1;
        w(10);
        chk(out_drive, 32'hFFFF_FFFE);
        rchk(`DFM_OFS_SHORT_LO, 32'h1);
        rchk(`DFM_OFS_TRIP, 32'h1);
        rchk(`DFM_OFS_CHFLT_LO, 32'h1);
        host.wr(`DFM_OFS_CHSEL, 32'h0);
        rchk(`DFM_OFS_CHSTAT, 32'h1);
        rchk(`DFM_OFS_MODSTAT, 32'h10);
        w(1);
        short_det <= 32'h0;
        w(RETRY + 10);
        chk(out_drive, 32'hFFFF_FFFE);
        host.react(32'h1);
        w(5);
        chk(out_drive, 32'hFFFF_FFFF);
        short_det <= 32'h100;
        w(RETRY + 10);
        host.react(32'h2);
        w(5);
        short_det <= 32'h0;
        w(10);
        rchk(`DFM_OFS_TRIP, 32'h2);
        host.react(32'h2);
        w(5);
        rchk(`DFM_OFS_TRIP, 32'h2);
        w(RETRY + 10);
        host.react(32'h2);
        w(5);
        rchk(`DFM_OFS_TRIP, 32'h0);
        host.wr(`DFM_OFS_CTRL, 32'h1);
        w(1);
        short_det <= 32'h1;
        w(10);
        rchk(`DFM_OFS_TRIP, 32'h1);
        cnt = 0;
        prev = out_drive[0];
        // Retries land about one period apart while the short stays
        repeat (2 * RETRY + 10) begin
            @(negedge clk);
            if (out_drive[0] === 1'b1 && prev === 1'b0) cnt++;
            prev = out_drive[0];
        end
        chk(cnt, 32'h2);
        w(1);
        short_det <= 32'h0;
        w(RETRY + 10);
        rchk(`DFM_OFS_TRIP, 32'h0);
        chk(out_drive, 32'hFFFF_FFFF);
        close_out();
    end
endmodule
